// [rtl/rpi_pkg.sv]
package rpi_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLK_PERIOD_NS = 5;

    // link clock rates in kHz
    localparam int TXC_1000_KHZ = 125000;
    localparam int TXC_100_KHZ = 25000;
    localparam int TXC_10_KHZ = 2500;
    localparam int REF_KHZ = 50000;

    function automatic int half_cyc(input int khz);
        int h;
        h = 1_000_000_000 / (khz * 2 * CLK_PERIOD_PS);
        return (h < 1) ? 1 : h;
    endfunction

    localparam logic [5:0] HP_1000 = 6'(half_cyc(TXC_1000_KHZ));
    localparam logic [5:0] HP_100 = 6'(half_cyc(TXC_100_KHZ));
    localparam logic [5:0] HP_10 = 6'(half_cyc(TXC_10_KHZ));
    localparam logic [5:0] HP_REF = 6'(half_cyc(REF_KHZ));
    localparam logic [3:0] RMII_DECIM_10 = 4'h9;

    // minimum internal clock delay and its cycle count
    localparam int DELAY_MIN_PS = 1500;
    localparam int DELAY_CYC = (DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC);
    localparam int STRAP_HOLD_NS = 50;
    localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] STRAP_LOAD = 4'(STRAP_HOLD_CYC);

    // register word indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_TXDATA = 4'h2;
    localparam logic [3:0] REG_RXDATA = 4'h3;

    // control fields
    localparam int CTL_MODE = 0;
    localparam int CTL_SPD = 1;
    localparam int CTL_FDX = 3;
    localparam int CTL_TXDLY = 4;
    localparam int CTL_RXDLY = 5;
    localparam int CTL_CLKSTRAP = 6;
    localparam int CTL_DEVRST = 7;
    localparam int CTL_SPDSTRAP = 8;
    localparam int CTL_W = 9;
    localparam logic [8:0] CTRL_RESET = 9'h1ED;

    // status fields
    localparam int ST_TXRDY = 0;
    localparam int ST_TXBUSY = 1;
    localparam int ST_RXV = 2;
    localparam int ST_OVR = 3;
    localparam int ST_RXERR = 4;
    localparam int ST_UNDER = 5;
    localparam int ST_SPDFLT = 6;
    localparam int ST_SETTLED = 7;
    localparam int ST_RXEND = 8;

    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;

    localparam logic [1:0] STRAP_RGMII = 2'h0;
    localparam logic [1:0] STRAP_RMII = 2'h1;

    typedef enum logic {TX_IDLE, TX_RUN} rpi_tx_state_t;
endpackage

// [rtl/rpi_host.sv]
`timescale 1ns/1ps
// How it works
// - RMII runs 10 or 100 Mbps only
// - one 50 MHz reference times both directions
// - RMII uses concurrent 2-bit paths
// - strap low: reference comes from outside
// - RGMII 10/100/1000, half and full duplex
// - RGMII separate 4-bit transmit, receive groups
// - MAC side sources transmit clock per speed
// - gigabit data on both clock edges
// - transmit control low until the clock settles
// - control merges valid and error, falling edge
// - attached PHY speed should be fixed
module rpi_host
    import rpi_pkg::*;
(
    input wire logic CLK, // system clock
    input wire logic RST, // async reset
    input wire logic [3:0] ADDR, // register word index
    input wire logic [31:0] WDATA, // write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    output logic [31:0] RDATA, // read data
    output logic DEV_RST, // device reset
    output logic SHARED_TX_REF_CLOCK_INPUT, // transmit clock or reference
    output logic TX_CTL, // transmit control or enable
    output logic [3:0] TXD, // transmit data
    input wire logic SHARED_RX_REF_CLOCK_OUTPUT, // receive clock or reference
    input wire logic RX_CTL, // receive control or valid
    input wire logic RX_ER, // rmii receive error
    input wire logic [3:0] RXD_I, // receive data pins in
    output logic [3:0] RXD_O, // strap drive
    output logic RXD_OE // strap drive enable
);
    logic [8:0] ctrl_reg, ctrl_next;
    logic is_rgmii, clk_norm, fdx, ctrl_wr, speed_fault, settled, carrier;
    logic [1:0] spd;
    always_comb begin
        is_rgmii = ctrl_reg[CTL_MODE];
        clk_norm = ctrl_reg[CTL_CLKSTRAP];
        fdx = ctrl_reg[CTL_FDX];
        ctrl_wr = WR && ADDR == REG_CTRL;
        speed_fault = !is_rgmii && ctrl_reg[CTL_SPD +: 2] == SPD_1000;
        spd = speed_fault ? SPD_100 : ctrl_reg[CTL_SPD +: 2];
    end

    // link clock divider
    logic [5:0] cnt_reg, cnt_next, hp;
    logic clk_reg, clk_next, txc_reg, txc_next, own_run, tgl, h_rise, h_fall;
    always_comb begin
        if (!is_rgmii) begin
            hp = HP_REF;
        end else if (spd == SPD_1000) begin
            hp = HP_1000;
        end else if (spd == SPD_100) begin
            hp = HP_100;
        end else begin
            hp = HP_10;
        end
        own_run = is_rgmii || clk_norm;
        tgl = cnt_reg >= hp - 6'd1;
        h_rise = own_run && tgl && !clk_reg;
        h_fall = own_run && tgl && clk_reg;
        cnt_next = tgl ? 6'd0 : cnt_reg + 6'd1;
        clk_next = tgl ? !clk_reg : clk_reg;
        if (!own_run || ctrl_wr) begin
            cnt_next = 6'd0;
            clk_next = 1'b0;
        end
        // without device delay the clock trails data by one cycle
        txc_next = ctrl_reg[CTL_TXDLY] ? clk_next : clk_reg;
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_reg <= 6'd0;
            clk_reg <= 1'b0;
            txc_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            clk_reg <= clk_next;
            txc_reg <= txc_next;
        end
    end

    // pin synchronisers and receive edge events
    logic [2:0] rxc_reg, rxc_next;
    logic [3:0] rxd_s1_reg, rxd_s2_reg;
    logic [1:0] ctl_s_reg, er_s_reg, orise_reg, orise_next, rxe_d_reg, rxe_d_next;
    logic rx_rise, rx_fall, rr, rf;
    always_comb begin
        rxc_next = {rxc_reg[1:0], SHARED_RX_REF_CLOCK_OUTPUT};
        rx_rise = rxc_reg[1] && !rxc_reg[2];
        rx_fall = !rxc_reg[1] && rxc_reg[2];
        orise_next = {orise_reg[0], h_rise};
        rxe_d_next = {rx_rise, rx_fall};
        rr = ctrl_reg[CTL_RXDLY] ? rx_rise : rxe_d_reg[1];
        rf = ctrl_reg[CTL_RXDLY] ? rx_fall : rxe_d_reg[0];
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rxc_reg <= 3'h0;
            rxd_s1_reg <= 4'h0;
            rxd_s2_reg <= 4'h0;
            ctl_s_reg <= 2'h0;
            er_s_reg <= 2'h0;
            orise_reg <= 2'h0;
            rxe_d_reg <= 2'h0;
        end else begin
            rxc_reg <= rxc_next;
            rxd_s1_reg <= RXD_I;
            rxd_s2_reg <= rxd_s1_reg;
            ctl_s_reg <= {ctl_s_reg[0], RX_CTL};
            er_s_reg <= {er_s_reg[0], RX_ER};
            orise_reg <= orise_next;
            rxe_d_reg <= rxe_d_next;
        end
    end

    // rmii 10 Mbps decimation, both directions on the one reference
    logic [3:0] tdec_reg, tdec_next, rdec_reg, rdec_next;
    logic t_ev, r_ev, tx_step, rx_step;
    always_comb begin
        t_ev = clk_norm ? h_fall : rx_rise;
        r_ev = clk_norm ? orise_reg[1] : rx_rise;
        tdec_next = t_ev ? (tdec_reg == RMII_DECIM_10 ? 4'h0 : tdec_reg + 4'h1) : tdec_reg;
        rdec_next = r_ev ? (rdec_reg == RMII_DECIM_10 ? 4'h0 : rdec_reg + 4'h1) : rdec_reg;
        tx_step = t_ev && (spd != SPD_10 || tdec_reg == 4'h0);
        rx_step = r_ev && (spd != SPD_10 || rdec_reg == 4'h0);
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tdec_reg <= 4'h0;
            rdec_reg <= 4'h0;
        end else begin
            tdec_reg <= tdec_next;
            rdec_reg <= rdec_next;
        end
    end

    // transmit engine
    rpi_tx_state_t tx_st_reg, tx_st_next;
    logic [7:0] cur_reg, cur_next, cur_sh;
    logic cur_err_reg, cur_err_next, cur_last_reg, cur_last_next;
    logic [2:0] pos_reg, pos_next;
    logic [9:0] hold_reg, hold_next;
    logic hold_v_reg, hold_v_next, txctl_reg, txctl_next, under_set, sym, adv, go;
    logic [3:0] txd_reg, txd_next, pos_sum;
    always_comb begin
        tx_st_next = tx_st_reg;
        cur_next = cur_reg;
        cur_err_next = cur_err_reg;
        cur_last_next = cur_last_reg;
        pos_next = pos_reg;
        hold_next = hold_reg;
        hold_v_next = hold_v_reg;
        txctl_next = txctl_reg;
        txd_next = txd_reg;
        under_set = 1'b0;
        cur_sh = cur_reg >> pos_reg;
        pos_sum = 4'h0;
        if (WR && ADDR == REG_TXDATA && !hold_v_reg) begin
            hold_next = WDATA[9:0];
            hold_v_next = 1'b1;
        end
        sym = is_rgmii ? h_rise : tx_step;
        adv = is_rgmii ? h_fall : tx_step;
        go = hold_v_reg && settled && (fdx || !carrier);
        if (sym) begin
            if (tx_st_reg == TX_IDLE) begin
                txctl_next = go;
                txd_next = 4'h0;
                if (go) begin
                    cur_next = hold_reg[7:0];
                    cur_err_next = hold_reg[8];
                    cur_last_next = hold_reg[9];
                    hold_v_next = 1'b0;
                    pos_next = 3'h0;
                    tx_st_next = TX_RUN;
                    txd_next = is_rgmii ? hold_reg[3:0] : {2'b00, hold_reg[1:0]};
                end
            end else begin
                txctl_next = 1'b1;
                txd_next = is_rgmii ? cur_sh[3:0] : {2'b00, cur_sh[1:0]};
            end
        end
        if (is_rgmii && adv && tx_st_reg == TX_RUN) begin
            txctl_next = 1'b1 ^ cur_err_reg;
            if (spd == SPD_1000) begin
                txd_next = cur_reg[7:4];
            end
        end
        if (adv && tx_st_next == TX_RUN) begin
            pos_sum = {1'b0, pos_next} + (!is_rgmii ? 4'h2 : (spd == SPD_1000 ? 4'h8 : 4'h4));
            pos_next = pos_sum[2:0];
            if (pos_sum[3]) begin
                if (cur_last_next) begin
                    tx_st_next = TX_IDLE;
                end else if (hold_v_next) begin
                    cur_next = hold_next[7:0];
                    cur_err_next = hold_next[8];
                    cur_last_next = hold_next[9];
                    hold_v_next = 1'b0;
                end else begin
                    under_set = 1'b1;
                    tx_st_next = TX_IDLE;
                end
            end
        end
        if (!settled) begin
            tx_st_next = TX_IDLE;
            txctl_next = 1'b0;
            txd_next = 4'h0;
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_st_reg <= TX_IDLE;
            cur_reg <= 8'h00;
            cur_err_reg <= 1'b0;
            cur_last_reg <= 1'b0;
            pos_reg <= 3'h0;
            hold_reg <= 10'h000;
            hold_v_reg <= 1'b0;
            txctl_reg <= 1'b0;
            txd_reg <= 4'h0;
        end else begin
            tx_st_reg <= tx_st_next;
            cur_reg <= cur_next;
            cur_err_reg <= cur_err_next;
            cur_last_reg <= cur_last_next;
            pos_reg <= pos_next;
            hold_reg <= hold_next;
            hold_v_reg <= hold_v_next;
            txctl_reg <= txctl_next;
            txd_reg <= txd_next;
        end
    end

    // receive engine
    logic [7:0] acc_reg, acc_next;
    logic [2:0] rpos_reg, rpos_next;
    logic rx_in_reg, rx_in_next, rdv_reg, rdv_next, rx_v_reg, rx_v_next, dlv, dlv_er;
    logic [8:0] rx_byte_reg, rx_byte_next;
    logic [7:0] dlv_byte;
    logic ovr_set, err_set, end_set, rx_rd;
    always_comb begin
        acc_next = acc_reg;
        rpos_next = rpos_reg;
        rx_in_next = rx_in_reg;
        rdv_next = rdv_reg;
        dlv = 1'b0;
        dlv_er = 1'b0;
        dlv_byte = 8'h00;
        end_set = 1'b0;
        carrier = rx_in_reg;
        if (is_rgmii) begin
            if (rr) begin
                rdv_next = ctl_s_reg[1];
                acc_next[rpos_reg[2] * 4 +: 4] = rxd_s2_reg;
                if (!ctl_s_reg[1]) begin
                    end_set = rx_in_reg;
                    rx_in_next = 1'b0;
                    rpos_next = 3'h0;
                end
            end
            if (rf && rdv_reg) begin
                rx_in_next = 1'b1;
                dlv_er = ctl_s_reg[1] ^ rdv_reg;
                if (spd == SPD_1000) begin
                    dlv = 1'b1;
                    dlv_byte = {rxd_s2_reg, acc_reg[3:0]};
                end else begin
                    dlv = rpos_reg[2];
                    dlv_byte = acc_reg;
                    rpos_next = rpos_reg[2] ? 3'h0 : 3'h4;
                end
            end
        end else if (rx_step) begin
            if (ctl_s_reg[1]) begin
                rx_in_next = 1'b1;
                acc_next[rpos_reg +: 2] = rxd_s2_reg[1:0];
                dlv = rpos_reg == 3'h6;
                dlv_byte = {rxd_s2_reg[1:0], acc_reg[5:0]};
                dlv_er = er_s_reg[1];
                rpos_next = rpos_reg + 3'h2;
            end else begin
                end_set = rx_in_reg;
                rx_in_next = 1'b0;
                rpos_next = 3'h0;
            end
        end
        rx_rd = RD && ADDR == REG_RXDATA;
        rx_byte_next = dlv ? {dlv_er, dlv_byte} : rx_byte_reg;
        ovr_set = dlv && rx_v_reg && !rx_rd;
        err_set = dlv && dlv_er;
        rx_v_next = dlv || (rx_v_reg && !rx_rd);
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            acc_reg <= 8'h00;
            rpos_reg <= 3'h0;
            rx_in_reg <= 1'b0;
            rdv_reg <= 1'b0;
            rx_v_reg <= 1'b0;
            rx_byte_reg <= 9'h000;
        end else begin
            acc_reg <= acc_next;
            rpos_reg <= rpos_next;
            rx_in_reg <= rx_in_next;
            rdv_reg <= rdv_next;
            rx_v_reg <= rx_v_next;
            rx_byte_reg <= rx_byte_next;
        end
    end

    // registers, straps, settling
    logic [3:0] sticky_reg, sticky_next, shold_reg, shold_next, rxd_o_next;
    logic [7:0] scnt_reg, scnt_next;
    logic [31:0] rdata_next, stat_word;
    logic rxd_oe_next;
    always_comb begin
        ctrl_next = ctrl_wr ? WDATA[CTL_W-1:0] : ctrl_reg;
        settled = scnt_reg == 8'h00;
        scnt_next = (ctrl_reg[CTL_DEVRST] || ctrl_wr) ? SETTLE_LOAD
            : (settled ? 8'h00 : scnt_reg - 8'h01);
        shold_next = ctrl_reg[CTL_DEVRST] ? STRAP_LOAD
            : (shold_reg == 4'h0 ? 4'h0 : shold_reg - 4'h1);
        rxd_oe_next = ctrl_reg[CTL_DEVRST] || shold_reg != 4'h0;
        rxd_o_next = {is_rgmii ? STRAP_RGMII : STRAP_RMII, clk_norm,
            ctrl_reg[CTL_SPDSTRAP]};
        // set wins over a write-one clear
        sticky_next = (sticky_reg & ~((WR && ADDR == REG_STAT) ? WDATA[ST_OVR +: 4] : 4'h0))
            | {end_set, under_set, err_set, ovr_set};
        stat_word = 32'h0000_0000;
        stat_word[ST_TXRDY] = !hold_v_reg;
        stat_word[ST_TXBUSY] = tx_st_reg == TX_RUN;
        stat_word[ST_RXV] = rx_v_reg;
        stat_word[ST_OVR +: 3] = sticky_reg[2:0];
        stat_word[ST_SPDFLT] = speed_fault;
        stat_word[ST_SETTLED] = settled;
        stat_word[ST_RXEND] = sticky_reg[3];
        rdata_next = 32'h0000_0000;
        if (RD) begin
            case (ADDR)
                REG_CTRL: rdata_next = {23'h00_0000, ctrl_reg};
                REG_STAT: rdata_next = stat_word;
                REG_TXDATA: rdata_next = {22'h00_0000, hold_reg};
                REG_RXDATA: rdata_next = {23'h00_0000, rx_byte_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg <= CTRL_RESET;
            scnt_reg <= SETTLE_LOAD;
            shold_reg <= STRAP_LOAD;
            sticky_reg <= 4'h0;
            RDATA <= 32'h0000_0000;
            DEV_RST <= 1'b1;
            RXD_O <= 4'h0;
            RXD_OE <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            scnt_reg <= scnt_next;
            shold_reg <= shold_next;
            sticky_reg <= sticky_next;
            RDATA <= rdata_next;
            DEV_RST <= ctrl_reg[CTL_DEVRST];
            RXD_O <= rxd_o_next;
            RXD_OE <= rxd_oe_next;
        end
    end

    always_comb begin
        SHARED_TX_REF_CLOCK_INPUT = txc_reg;
        TX_CTL = txctl_reg;
        TXD = txd_reg;
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_hold_low;
        !settled |=> !TX_CTL;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("tx control not low");

    property p_rmii_speed;
        !is_rgmii |-> spd != SPD_1000;
    endproperty
    a_rmii_speed: assert property (p_rmii_speed) else $error("rmii at gigabit");

    sequence s_rmii_norm;
        (!is_rgmii && clk_norm && !ctrl_wr) [*6];
    endsequence
    property p_ref_runs;
        s_rmii_norm |-> SHARED_TX_REF_CLOCK_INPUT != $past(SHARED_TX_REF_CLOCK_INPUT, 2);
    endproperty
    a_ref_runs: assert property (p_ref_runs) else $error("reference not 50 MHz");

    property p_ref_quiet;
        (!is_rgmii && !clk_norm) [*2] |-> !SHARED_TX_REF_CLOCK_INPUT;
    endproperty
    a_ref_quiet: assert property (p_ref_quiet) else $error("reference driven");

    property p_strap;
        ctrl_reg[CTL_DEVRST] |=> RXD_OE && RXD_O == $past(rxd_o_next);
    endproperty
    a_strap: assert property (p_strap) else $error("straps not driven");

    property p_fall_ctl;
        is_rgmii && h_fall && tx_st_reg == TX_RUN && settled
            |=> TX_CTL == !$past(cur_err_reg);
    endproperty
    a_fall_ctl: assert property (p_fall_ctl) else $error("falling control wrong");

    property p_rmii_dibit;
        !is_rgmii |=> TXD[3:2] == 2'b00;
    endproperty
    a_rmii_dibit: assert property (p_rmii_dibit) else $error("rmii upper bits set");

    sequence s_ctrl_wr_rd;
        ctrl_wr ##1 (RD && ADDR == REG_CTRL && !WR);
    endsequence
    property p_speed_rb;
        s_ctrl_wr_rd |=> RDATA[CTL_SPD +: 2] == $past(WDATA[CTL_SPD +: 2], 2);
    endproperty
    a_speed_rb: assert property (p_speed_rb) else $error("speed not written");

    property p_defer;
        !fdx && carrier && tx_st_reg == TX_IDLE |=> tx_st_reg == TX_IDLE;
    endproperty
    a_defer: assert property (p_defer) else $error("sent into carrier");

    property p_txdly;
        !ctrl_reg[CTL_TXDLY] && $stable(ctrl_reg) && !$past(ctrl_wr)
            |-> SHARED_TX_REF_CLOCK_INPUT == $past(clk_reg, DELAY_CYC);
    endproperty
    a_txdly: assert property (p_txdly) else $error("tx clock not delayed");
endmodule

// [testbench/rpi_dev_mdl.sv]
`timescale 1ns/1ps
module rpi_dev_mdl (
    input wire logic dev_rst, // device reset from host
    input wire logic txc, // transmit clock from host
    input wire logic tx_ctl, // transmit control
    input wire logic [3:0] txd, // transmit nibble
    input wire logic [3:0] rxd_pin, // resolved receive data wires
    output logic rxc, // receive clock
    output logic rx_ctl, // receive control, same role to MAC or PHY
    output logic rx_er, // rmii receive error
    output logic [3:0] rxd // receive data drive
);
    logic [3:0] strap_q;
    logic [3:0] nib_q[$];
    logic fall_q[$];
    logic rise_ctl = 1'b0;
    initial begin
        rxc = 1'b0;
        rx_ctl = 1'b0;
        rx_er = 1'b0;
        rxd = 4'h0;
    end
    // straps are latched as the device leaves reset
    always @(negedge dev_rst) #1 strap_q = rxd_pin;
    // transmit pins are inputs here; sample well after the launching edge
    always @(posedge txc) begin
        #7;
        rise_ctl = tx_ctl;
        if (tx_ctl) nib_q.push_back(txd);
    end
    always @(negedge txc) begin
        #7;
        if (rise_ctl) fall_q.push_back(tx_ctl);
    end
    // one nibble per period, valid at rise, valid xor error at fall
    task automatic send_byte(input logic [7:0] b, input logic e);
        for (int i = 0; i < 2; i++) begin
            rxd = b[4*i +: 4];
            rx_ctl = 1'b1;
            #31 rxc = 1'b1;
            #31 rx_ctl = 1'b1 ^ e;
            #31 rxc = 1'b0;
            #32;
        end
    endtask
    // two idle periods end the frame, then the clock stands still
    task automatic tail();
        rx_ctl = 1'b0;
        repeat (2) begin
            rxd = ~rxd;
            #31 rxc = 1'b1;
            #62 rxc = 1'b0;
            #32;
        end
    endtask
endmodule

// [testbench/rpi_host_tb_top.sv]
`timescale 1ns/1ps
module rpi_host_tb_top;
    import rpi_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0000_0000;
    logic [31:0] rdat, d;
    logic [3:0] rxd_o, rxd_m, rxd_w, txd;
    logic rxd_oe, dev_rst, txc, tx_ctl, rxc, rx_ctl, rx_er, p;
    int fail_count = 0;
    int n_tests = 0;
    int rises;
    localparam logic [11:0] CV [6] = '{12'h16D, 12'h16B, 12'h169, 12'h16A, 12'h16C, 12'h12A};
    localparam int ER [6] = '{40, 10, 1, 20, 20, 0};
    assign rxd_w = rxd_oe ? rxd_o : rxd_m;
    always #2.5 CLK = ~CLK;
    rpi_host i_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(rdat), .DEV_RST(dev_rst), .SHARED_TX_REF_CLOCK_INPUT(txc), .TX_CTL(tx_ctl),
        .TXD(txd), .SHARED_RX_REF_CLOCK_OUTPUT(rxc), .RX_CTL(rx_ctl), .RX_ER(rx_er),
        .RXD_I(rxd_w), .RXD_O(rxd_o), .RXD_OE(rxd_oe));
    rpi_dev_mdl i_dev (.dev_rst(dev_rst), .txc(txc), .tx_ctl(tx_ctl), .txd(txd),
        .rxd_pin(rxd_w), .rxc(rxc), .rx_ctl(rx_ctl), .rx_er(rx_er), .rxd(rxd_m));
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    // write then read back, the strobes back to back
    task wr_rd(input logic [3:0] a, input logic [31:0] v, output logic [31:0] r);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 r = rdat;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = rdat;
    endtask
    // poll status until a bit reaches a value, bounded
    task wait_st(input int b, input logic v);
        for (int i = 0; i < 3000; i++) begin
            rd(REG_STAT, d);
            if (d[b] === v) break;
        end
    endtask
    task test_done();
        $display("mismatches %0d, checks %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #400_000;
        fail_count++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        #1;
        chk(32'(rxd_o), 32'h0000_0003);
        chk(32'(rxd_oe), 32'h0000_0001);
        rd(REG_CTRL, d);
        chk(d, 32'(CTRL_RESET));
        rd(4'hF, d);
        chk(d, 32'h0000_0000);
        // release the device, software picks 100 Mbps
        wr(REG_CTRL, 32'h0000_016B);
        #1 chk(32'(tx_ctl), 32'h0000_0000);
        repeat (14) @(posedge CLK);
        #1 chk(32'(rxd_oe), 32'h0000_0000);
        chk(32'(i_dev.strap_q), 32'h0000_0003);
        wait_st(ST_SETTLED, 1'b1);
        chk(32'(d[ST_SETTLED]), 32'h0000_0001);
        // two bytes back to back, the second with error and last
        wr(REG_TXDATA, 32'h0000_00A5);
        wait_st(ST_TXRDY, 1'b1);
        wr(REG_TXDATA, 32'h0000_033C);
        wait_st(ST_TXBUSY, 1'b0);
        repeat (40) @(posedge CLK);
        chk(32'(i_dev.nib_q.size()), 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            chk(32'(i_dev.nib_q[i]), 32'(16'h3CA5 >> (4 * i)) & 32'hF);
            chk(32'(i_dev.fall_q[i]), 32'(4'b0011 >> i) & 32'h1);
        end
        // half duplex: a byte written mid-frame waits for the carrier to drop
        wr(REG_CTRL, 32'h0000_0163);
        wait_st(ST_SETTLED, 1'b1);
        // receive: one clean byte, one errored byte
        fork
            begin
                i_dev.send_byte(8'h5A, 1'b0);
                i_dev.send_byte(8'h96, 1'b1);
                i_dev.tail();
            end
            begin
                wait_st(ST_RXV, 1'b1);
                rd(REG_RXDATA, d);
                chk(d, 32'h0000_005A);
                wr(REG_TXDATA, 32'h0000_0200);
                repeat (20) @(posedge CLK);
                rd(REG_STAT, d);
                chk(32'(d[ST_TXBUSY:ST_TXRDY]), 32'h0000_0000);
                wait_st(ST_RXV, 1'b1);
                rd(REG_RXDATA, d);
                chk(d, 32'h0000_0196);
            end
        join
        repeat (20) @(posedge CLK);
        rd(REG_STAT, d);
        chk(32'(d[ST_RXEND]), 32'h0000_0001);
        chk(32'(d[ST_TXRDY]), 32'h0000_0001);
        chk(32'(i_dev.nib_q.size()), 32'h0000_0006);
        wr(REG_STAT, 32'h0000_0040);
        rd(REG_STAT, d);
        chk(32'(d[ST_RXEND]), 32'h0000_0000);
        // link clock rate per mode, speed and clocking strap
        for (int k = 0; k < 6; k++) begin
            wr_rd(REG_CTRL, 32'(CV[k]), d);
            chk(d, 32'(CV[k]));
            repeat (20) @(posedge CLK);
            rises = 0;
            #1 p = txc;
            repeat (80) begin
                @(posedge CLK);
                #1;
                if (txc && !p) rises++;
                p = txc;
            end
            chk(32'(rises), 32'(ER[k]));
            rd(REG_STAT, d);
            chk(32'(d[ST_SPDFLT]), 32'(k == 4));
        end
        test_done();
    end
endmodule
